//--- test_dual_digital_tone_oscillator.sv
`timescale 1ns/100ps
module test_dual_digital_tone_oscillator;
    import tone_gen_pkg::*;
    localparam int TICK    = 20;
    localparam int CEILING = 5000;
    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  ind_addr = 8'h00;
    logic [15:0] ind_wdata = 16'h0000;
    logic        ind_write = 1'b0;
    logic        ind_read = 1'b0;
    logic [1:0]  osc_en = 2'b00;
    logic [1:0]  act_en = 2'b00;
    logic [1:0]  inact_en = 2'b00;
    logic [15:0] act_t [2] = '{16'h0000, 16'h0000};
    logic [15:0] inact_t [2] = '{16'h0000, 16'h0000};
    logic [1:0]  route [2] = '{2'b00, 2'b00};
    logic [15:0] ind_rdata, rx_tone, tx_tone, rx_sample, tx_sample;
    logic        ind_busy, sample_strobe;
    logic [1:0]  gen_running;
    logic [31:0] sample_gap;
    int          seed = 32'h6579;
    int          failures = 0;
    int          tests_run = 0;
    int          cycles = 0;

    tone_gen #(.TICK_CYCLES(TICK)) tone_gen_inst (
        .clock(clock), .reset_n(reset_n), .ind_addr(ind_addr), .ind_wdata(ind_wdata),
        .ind_write(ind_write), .ind_read(ind_read), .ind_rdata(ind_rdata), .ind_busy(ind_busy),
        .gen_a_osc_enable(osc_en[0]), .gen_b_osc_enable(osc_en[1]),
        .gen_a_active_timer_en(act_en[0]), .gen_b_active_timer_en(act_en[1]),
        .gen_a_inactive_timer_en(inact_en[0]), .gen_b_inactive_timer_en(inact_en[1]),
        .gen_a_active_timer(act_t[0]), .gen_b_active_timer(act_t[1]),
        .gen_a_inactive_timer(inact_t[0]), .gen_b_inactive_timer(inact_t[1]),
        .gen_a_route(route[0]), .gen_b_route(route[1]), .rx_tone(rx_tone), .tx_tone(tx_tone),
        .sample_strobe(sample_strobe), .gen_running(gen_running));

    voice_path_sink voice_path_sink_inst (
        .clock(clock), .reset_n(reset_n), .sample_strobe(sample_strobe), .rx_tone(rx_tone),
        .tx_tone(tx_tone), .rx_sample(rx_sample), .tx_sample(tx_sample), .sample_gap(sample_gap));

    // =====================================================================
    // Clock and hang guard
    // Clock toggles every half period; the guard cuts a stuck run short.
    always #5 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == CEILING) begin
            failures++;
            $display("Error run ceiling reached after %0d cycles", cycles);
            conclude();
        end
    end

    // =====================================================================
    // Helpers
    task automatic step();
        @(posedge clock);
        #1;
    endtask
    task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_count(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    // One write, then a spare cycle so the busy guard has passed.
    task automatic write_ind(input logic [7:0] a, input logic [15:0] d);
        ind_addr  = a;
        ind_wdata = d;
        ind_write = 1'b1;
        step();
        ind_write = 1'b0;
        step();
    endtask
    task automatic read_ind(input logic [7:0] a, output logic [15:0] d);
        ind_addr = a;
        ind_read = 1'b1;
        step();
        d = ind_rdata;
        ind_read = 1'b0;
        step();
    endtask
    // Waits for the next strobe under a bound; a missing strobe is a mismatch.
    task automatic next_strobe();
        for (int n = 0; n < 3 * TICK; n++) begin
            step();
            if (sample_strobe === 1'b1) break;
        end
        check_count("sample strobe", 32'd1, {31'd0, sample_strobe});
    endtask
    // Saturating fixed-point step of the two-pole recursion.
    function automatic logic [15:0] next_y(input logic [15:0] c, y1, y2);
        longint v;
        v = ((longint'($signed(c)) * longint'($signed(y1))) >>> 14) - longint'($signed(y2));
        if (v > 32767) return 16'h7fff;
        if (v < -32768) return 16'h8000;
        return v[15:0];
    endfunction

    // Loads one generator, runs it on the given route, checks the stream and the stop.
    task automatic run_tone(input int g, input logic [15:0] c, amp, ph, input logic [1:0] rt);
        logic [15:0] y1, y2, yn;
        write_ind(8'(3 * g), c);
        write_ind(8'(3 * g + 1), amp);
        write_ind(8'(3 * g + 2), ph);
        route[g] = rt;
        route[1 - g] = 2'($random(seed));
        next_strobe();
        osc_en[g] = 1'b1;
        next_strobe();
        check_word("first sample", 16'h0000, rx_tone | tx_tone);
        y1 = amp;
        y2 = ph;
        for (int k = 0; k < 8; k++) begin
            next_strobe();
            check_word("receive sample", rt[0] ? y1 : 16'h0000, rx_tone);
            check_word("transmit sample", rt[1] ? y1 : 16'h0000, tx_tone);
            yn = next_y(c, y1, y2);
            y2 = y1;
            y1 = yn;
        end
        check_count("running flags", 32'(1 << g), {30'd0, gen_running});
        osc_en[g] = 1'b0;
        next_strobe();
        next_strobe();
        check_word("receive when off", 16'h0000, rx_tone);
        check_word("transmit when off", 16'h0000, tx_tone);
        check_count("running when off", 32'd0, {30'd0, gen_running});
        step();
        check_count("sample gap", TICK, sample_gap);
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // =====================================================================
    // Main sequence
    // Reset, coefficient storage, refused accesses, tone streams, cadence.
    initial begin
        logic [15:0] rd;
        logic [15:0] words [6];
        int          cnt;
        repeat (4) @(posedge clock);
        #1 reset_n = 1'b1;
        check_word("receive at reset", 16'h0000, rx_tone);
        check_count("busy at reset", 32'd0, {31'd0, ind_busy});
        for (int i = 0; i < 6; i++) begin
            read_ind(8'(i), rd);
            check_word("coefficient reset", COEFF_RESET, rd);
            words[i] = 16'($random(seed));
            write_ind(8'(i), words[i]);
        end
        for (int i = 0; i < 6; i++) begin
            read_ind(8'(i), rd);
            check_word("coefficient word", words[i], rd);
        end
        write_ind(8'h06, 16'hffff);
        read_ind(8'h06, rd);
        check_word("unmapped word", 16'h0000, rd);
        ind_addr  = 8'h00;
        ind_wdata = 16'h1234;
        ind_write = 1'b1;
        step();
        ind_wdata = 16'h5678;
        check_count("busy after write", 32'd1, {31'd0, ind_busy});
        step();
        ind_write = 1'b0;
        step();
        read_ind(8'h00, rd);
        check_word("write while busy", 16'h1234, rd);
        run_tone(0, 16'h78e6, 16'h02b3, 16'h0000, 2'b01);
        run_tone(1, 16'h6ec9, 16'h044b, 16'h0000, 2'b10);
        for (int i = 0; i < 4; i++) begin
            run_tone(i % 2, 16'($random(seed)), 16'($random(seed)), 16'($random(seed)),
                     2'((i + 1) % 3 + 1));
        end
        for (int i = 0; i < 2; i++) begin
            act_t[0] = 16'(2 * i);
            inact_t[0] = 16'($random(seed));
            act_en[0] = 1'b1;
            osc_en[0] = 1'b1;
            cnt = 0;
            repeat (16) begin
                next_strobe();
                if (gen_running[0] === 1'b1) cnt++;
            end
            check_count("one-shot samples", SAMPLES_PER_STEP * (i + 1), cnt);
            osc_en[0] = 1'b0;
            act_en[0] = 1'b0;
            repeat (2) next_strobe();
        end
        // Repeating cadence: one step on, one step off.
        act_t[0] = 16'h0001;
        inact_t[0] = 16'h0001;
        act_en[0] = 1'b1;
        inact_en[0] = 1'b1;
        osc_en[0] = 1'b1;
        cnt = 0;
        repeat (16) begin
            next_strobe();
            if (gen_running[0] === 1'b1) cnt++;
        end
        check_count("cadence samples", 32'(4 * SAMPLES_PER_STEP), cnt);
        osc_en[0] = 1'b0;
        act_en[0] = 1'b0;
        inact_en[0] = 1'b0;
        repeat (2) next_strobe();
        conclude();
    end
endmodule

//--- tone_gen.sv
`timescale 1ns/100ps
module tone_gen
    import tone_gen_pkg::*;
#(
    parameter int TICK_CYCLES = SAMPLE_CYCLES
) (
    input  wire logic        clock,                   // Core clock, 100 MHz.
    input  wire logic        reset_n,                 // Synchronous reset, active low.
    input  wire logic [7:0]  ind_addr,                // Indirect address.
    input  wire logic [15:0] ind_wdata,               // Indirect write data.
    input  wire logic        ind_write,               // Indirect write strobe.
    input  wire logic        ind_read,                // Indirect read strobe.
    output logic      [15:0] ind_rdata,               // Indirect read data.
    output logic             ind_busy,                // Write guard status, high the cycle after an accepted write.
    input  wire logic        gen_a_osc_enable,        // Generator A oscillator enable.
    input  wire logic        gen_b_osc_enable,        // Generator B oscillator enable.
    input  wire logic        gen_a_active_timer_en,   // Generator A active timer enable.
    input  wire logic        gen_b_active_timer_en,   // Generator B active timer enable.
    input  wire logic        gen_a_inactive_timer_en, // Generator A inactive timer enable.
    input  wire logic        gen_b_inactive_timer_en, // Generator B inactive timer enable.
    input  wire logic [15:0] gen_a_active_timer,      // Generator A active period, 125 us units.
    input  wire logic [15:0] gen_b_active_timer,      // Generator B active period.
    input  wire logic [15:0] gen_a_inactive_timer,    // Generator A inactive period.
    input  wire logic [15:0] gen_b_inactive_timer,    // Generator B inactive period.
    input  wire logic [1:0]  gen_a_route,             // Generator A route, bit0 rx, bit1 tx.
    input  wire logic [1:0]  gen_b_route,             // Generator B route.
    output logic      [15:0] rx_tone,                 // Receive path tone sample.
    output logic      [15:0] tx_tone,                 // Transmit path tone sample.
    output logic             sample_strobe,           // New sample pulse.
    output logic      [1:0]  gen_running              // Oscillating flags, bit0 A.
);

    // =====================================================================
    // Arithmetic helpers

    // Clamps an 18-bit signed value to the 16-bit sample range.
    function automatic logic signed [15:0] sat16(input logic signed [17:0] v);
        if (v > 18'sd32767) begin
            return 16'sh7fff;
        end else if (v < -18'sd32768) begin
            return 16'sh8000;
        end
        return v[15:0];
    endfunction

    // One step of the resonator: 2*c*y1 - y2 with c in Q15.
    function automatic logic signed [15:0] osc_step(input logic signed [15:0] c,
                                                    input logic signed [15:0] yp,
                                                    input logic signed [15:0] ypp);
        logic signed [31:0] prod;
        logic signed [17:0] acc;
        prod = c * yp;
        acc  = $signed(prod[31:14]) - $signed({{2{ypp[15]}}, ypp});
        return sat16(acc);
    endfunction

    // =====================================================================
    // Storage and control vectors
    logic        [15:0] freq_coeff  [NUM_GEN];
    logic        [15:0] amp_coeff   [NUM_GEN];
    logic        [15:0] phase_coeff [NUM_GEN];
    logic signed [15:0] y1          [NUM_GEN];
    logic signed [15:0] y2          [NUM_GEN];
    cadence_type        cad_state   [NUM_GEN];
    logic        [15:0] cad_count   [NUM_GEN];
    logic        [15:0] act_time    [NUM_GEN];
    logic        [15:0] inact_time  [NUM_GEN];
    logic        [1:0]  route       [NUM_GEN];
    logic [NUM_GEN-1:0] osc_en;
    logic [NUM_GEN-1:0] ta_en;
    logic [NUM_GEN-1:0] ti_en;
    logic [NUM_GEN-1:0] run;
    logic [NUM_GEN-1:0] run_q;
    logic        [15:0] tick_cnt;
    logic        [3:0]  step_div;
    logic               sample_tick;
    logic               step_tick;
    logic [7:0]         gen_base    [NUM_GEN];

    // Gathers the per-generator inputs into indexed form.
    always_comb begin
        osc_en        = {gen_b_osc_enable, gen_a_osc_enable};
        ta_en         = {gen_b_active_timer_en, gen_a_active_timer_en};
        ti_en         = {gen_b_inactive_timer_en, gen_a_inactive_timer_en};
        act_time[0]   = gen_a_active_timer;
        act_time[1]   = gen_b_active_timer;
        inact_time[0] = gen_a_inactive_timer;
        inact_time[1] = gen_b_inactive_timer;
        route[0]      = gen_a_route;
        route[1]      = gen_b_route;
        gen_base[0]   = IND_GEN_A_BASE;
        gen_base[1]   = IND_GEN_B_BASE;
    end

    // =====================================================================
    // Sample and timer-step ticks

    // Divides the core clock down to the sample rate.
    assign sample_tick = (tick_cnt == 16'(TICK_CYCLES - 1));
    assign step_tick   = sample_tick && (step_div == 4'(SAMPLES_PER_STEP - 1));

    // Sample tick divider and 125 us step divider.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            tick_cnt <= 16'h0000;
            step_div <= 4'h0;
        end else begin
            tick_cnt <= sample_tick ? 16'h0000 : tick_cnt + 16'h0001;
            if (step_tick) begin
                step_div <= 4'h0;
            end else if (sample_tick) begin
                step_div <= step_div + 4'h1;
            end
        end
    end

    // =====================================================================
    // Indirect coefficient access

    // Writes land at once; busy guards the following cycle.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            for (int g = 0; g < NUM_GEN; g++) begin
                freq_coeff[g]  <= COEFF_RESET;
                amp_coeff[g]   <= COEFF_RESET;
                phase_coeff[g] <= COEFF_RESET;
            end
            ind_busy <= 1'b0;
        end else begin
            ind_busy <= ind_write && !ind_busy;
            if (ind_write && !ind_busy) begin
                for (int g = 0; g < NUM_GEN; g++) begin
                    if (ind_addr == gen_base[g] + IND_FREQ_OFS) begin
                        freq_coeff[g] <= ind_wdata;
                    end
                    if (ind_addr == gen_base[g] + IND_AMP_OFS) begin
                        amp_coeff[g] <= ind_wdata;
                    end
                    if (ind_addr == gen_base[g] + IND_PHASE_OFS) begin
                        phase_coeff[g] <= ind_wdata;
                    end
                end
            end
        end
    end

    // Read data; unmapped addresses read zero.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ind_rdata <= 16'h0000;
        end else if (ind_read) begin
            ind_rdata <= 16'h0000;
            for (int g = 0; g < NUM_GEN; g++) begin
                if (ind_addr == gen_base[g] + IND_FREQ_OFS) begin
                    ind_rdata <= freq_coeff[g];
                end
                if (ind_addr == gen_base[g] + IND_AMP_OFS) begin
                    ind_rdata <= amp_coeff[g];
                end
                if (ind_addr == gen_base[g] + IND_PHASE_OFS) begin
                    ind_rdata <= phase_coeff[g];
                end
            end
        end
    end

    // =====================================================================
    // Cadence timers

    // Steps each generator between active and inactive periods.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            for (int g = 0; g < NUM_GEN; g++) begin
                cad_state[g] <= CAD_IDLE;
                cad_count[g] <= 16'h0000;
            end
        end else begin
            for (int g = 0; g < NUM_GEN; g++) begin
                if (!osc_en[g] || !(ta_en[g] || ti_en[g])) begin
                    cad_state[g] <= CAD_IDLE;
                    cad_count[g] <= 16'h0000;
                end else if (step_tick) begin
                    unique case (cad_state[g])
                        CAD_IDLE: begin
                            cad_state[g] <= ta_en[g] ? CAD_ACTIVE : CAD_INACTIVE;
                            cad_count[g] <= 16'h0000;
                        end
                        CAD_ACTIVE: begin
                            if ({1'b0, cad_count[g]} + 17'd1 >= {1'b0, act_time[g]}) begin
                                cad_state[g] <= ti_en[g] ? CAD_INACTIVE : CAD_DONE;
                                cad_count[g] <= 16'h0000;
                            end else begin
                                cad_count[g] <= cad_count[g] + 16'h0001;
                            end
                        end
                        CAD_INACTIVE: begin
                            if ({1'b0, cad_count[g]} + 17'd1 >= {1'b0, inact_time[g]}) begin
                                cad_state[g] <= ta_en[g] ? CAD_ACTIVE : CAD_DONE;
                                cad_count[g] <= 16'h0000;
                            end else begin
                                cad_count[g] <= cad_count[g] + 16'h0001;
                            end
                        end
                        CAD_DONE: begin
                            cad_count[g] <= 16'h0000;
                        end
                    endcase
                end
            end
        end
    end

    // Oscillation gate: direct enable or the active period of the cadence.
    always_comb begin
        for (int g = 0; g < NUM_GEN; g++) begin
            if (!(ta_en[g] || ti_en[g])) begin
                run[g] = osc_en[g];
            end else begin
                run[g] = osc_en[g] && (cad_state[g] == CAD_ACTIVE);
            end
        end
    end

    // =====================================================================
    // Resonators and routing

    // Seeds on a fresh start, iterates while running.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            for (int g = 0; g < NUM_GEN; g++) begin
                y1[g] <= 16'sh0000;
                y2[g] <= 16'sh0000;
            end
            run_q <= '0;
        end else if (sample_tick) begin
            run_q <= run;
            for (int g = 0; g < NUM_GEN; g++) begin
                if (run[g] && !run_q[g]) begin
                    y1[g] <= amp_coeff[g];
                    y2[g] <= phase_coeff[g];
                end else if (run[g]) begin
                    y1[g] <= osc_step(freq_coeff[g], y1[g], y2[g]);
                    y2[g] <= y1[g];
                end else begin
                    y1[g] <= 16'sh0000;
                    y2[g] <= 16'sh0000;
                end
            end
        end
    end

    // Mixes running generators onto the selected paths.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rx_tone       <= 16'h0000;
            tx_tone       <= 16'h0000;
            sample_strobe <= 1'b0;
            gen_running   <= '0;
        end else begin
            sample_strobe <= sample_tick;
            gen_running   <= run;
            if (sample_tick) begin
                rx_tone <= sat16(
                    ((run[0] && route[0][ROUTE_RX_BIT]) ? 18'(y1[0]) : 18'sd0) +
                    ((run[1] && route[1][ROUTE_RX_BIT]) ? 18'(y1[1]) : 18'sd0));
                tx_tone <= sat16(
                    ((run[0] && route[0][ROUTE_TX_BIT]) ? 18'(y1[0]) : 18'sd0) +
                    ((run[1] && route[1][ROUTE_TX_BIT]) ? 18'(y1[1]) : 18'sd0));
            end
        end
    end

    // =====================================================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    logic [15:0] gap;
    // Counts cycles since the last sample strobe.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            gap <= 16'h0000;
        end else begin
            gap <= sample_strobe ? 16'h0001 : gap + 16'h0001;
        end
    end

    sequence s_fresh_start;
        sample_tick && run[0] && !run_q[0];
    endsequence

    a_sample_spacing: assert property (sample_strobe && $past(sample_strobe, 2) == 1'b0
        && gap != 16'h0000 |-> gap == 16'(TICK_CYCLES) || $past(gap) == 16'h0000)
        else $error("sample strobe spacing wrong");
    a_silent_disabled: assert property (sample_tick && !run[0] && !run[1]
        |=> rx_tone == 16'h0000 && tx_tone == 16'h0000)
        else $error("disabled generators not silent");
    a_seed_from_amp: assert property (s_fresh_start |=> y1[0] == $past(amp_coeff[0]))
        else $error("oscillator not seeded from amplitude");
    a_recursion_shift: assert property (sample_tick && run[0] && run_q[0]
        |=> y2[0] == $past(y1[0]))
        else $error("recursion state not shifted");
    a_direct_enable: assert property (!ta_en[1] && !ti_en[1] |-> run[1] == osc_en[1])
        else $error("direct enable not obeyed");
    a_route_tx_only: assert property (sample_tick && run[0] && !run[1] && route[0] == 2'b10
        |=> rx_tone == 16'h0000 && $signed(tx_tone) == $past(y1[0]))
        else $error("route select not obeyed");
    a_coeff_write: assert property (ind_write && !ind_busy && ind_addr == IND_GEN_B_BASE + IND_AMP_OFS
        |=> amp_coeff[1] == $past(ind_wdata) && ind_busy)
        else $error("indirect write lost");
    a_coeff_read: assert property (ind_read && ind_addr == IND_GEN_A_BASE
        |=> ind_rdata == $past(freq_coeff[0]))
        else $error("indirect read wrong");
    a_cadence_switch: assert property (step_tick && osc_en[0] && cad_state[0] == CAD_ACTIVE
        && ti_en[0] && cad_count[0] + 16'h0001 >= act_time[0] && act_time[0] != 16'hffff
        |=> cad_state[0] == CAD_INACTIVE && !run[0])
        else $error("active period did not end");

endmodule

//--- tone_gen_pkg.sv
package tone_gen_pkg;

    // =====================================================================
    // Timing
    localparam int CLOCK_HZ         = 100_000_000;
    localparam int SAMPLE_RATE_HZ   = 16_000;
    localparam int SAMPLE_CYCLES    = CLOCK_HZ / SAMPLE_RATE_HZ;
    localparam int TIMER_STEP_US    = 125;
    localparam int SAMPLES_PER_STEP = TIMER_STEP_US * SAMPLE_RATE_HZ / 1_000_000;

    // =====================================================================
    // Widths and reset values
    localparam int              NUM_GEN     = 2;
    localparam int              COEFF_W     = 16;
    localparam logic [15:0]     COEFF_RESET = 16'h0000;

    // =====================================================================
    // Indirect address map
    localparam logic [7:0] IND_GEN_A_BASE = 8'h00;
    localparam logic [7:0] IND_GEN_B_BASE = 8'h03;
    localparam logic [7:0] IND_FREQ_OFS   = 8'h00;
    localparam logic [7:0] IND_AMP_OFS    = 8'h01;
    localparam logic [7:0] IND_PHASE_OFS  = 8'h02;

    // =====================================================================
    // Route select field positions
    localparam int ROUTE_RX_BIT = 0;
    localparam int ROUTE_TX_BIT = 1;

    typedef enum logic [1:0] {
        CAD_IDLE     = 2'b00,
        CAD_ACTIVE   = 2'b01,
        CAD_INACTIVE = 2'b10,
        CAD_DONE     = 2'b11
    } cadence_type;

endpackage

//--- voice_path_sink.sv
`timescale 1ns/100ps
// =====================================================================
// Voice path sink
// Stands in for the receive and transmit voice paths: each strobe hands both
// paths one sample, and the gap counter shows the sample rate they really see.
module voice_path_sink (
    input  wire logic        clock,         // Core clock.
    input  wire logic        reset_n,       // Synchronous reset, active low.
    input  wire logic        sample_strobe, // New sample pulse.
    input  wire logic [15:0] rx_tone,       // Receive path tone sample.
    input  wire logic [15:0] tx_tone,       // Transmit path tone sample.
    output logic      [15:0] rx_sample,     // Last sample taken by the receive path.
    output logic      [15:0] tx_sample,     // Last sample taken by the transmit path.
    output logic      [31:0] sample_gap     // Clocks between the last two strobes.
);
    logic [31:0] gap_count;

    // Takes one sample per strobe and measures the strobe spacing.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rx_sample  <= 16'h0000;
            tx_sample  <= 16'h0000;
            sample_gap <= 32'h0000_0000;
            gap_count  <= 32'h0000_0000;
        end else if (sample_strobe) begin
            rx_sample  <= rx_tone;
            tx_sample  <= tx_tone;
            sample_gap <= gap_count + 1;
            gap_count  <= 32'h0000_0000;
        end else begin
            gap_count <= gap_count + 1;
        end
    end
endmodule
